/* design/dpt_core.sv */
// dpt_core: dual preset timer core with stop-at-preset-2 modes,
// output control, preset tracking, timed outputs and access decode.
// assumes the menu drives settings as levels on the core clock and the
// retained timer value comes from nonvolatile storage at power-up.
`timescale 1ns/10ps

// What this block does
// [RL1] modes 19 to 42 stop timing at preset 2, with mode reset types
// [RL2] power-up reset off restores the stored timer value
// [RL3] power-up reset on clears the timer at power-up
// [RL4] each preset has its own access level
// [RL5] locked values are hidden everywhere outside programming
// [RL6] protected values appear only in the protected value menu
// [RL7] view-only values show on main display, edit only when enabled
// [RL8] full access values edit from main display, not in menu
// [RL9] each output time has its own access level, same four
// [RL10] preset 1 activates output 1
// [RL11] preset 2 activates output 2
// [RL12] tracking: changing preset 2 moves preset 1 keeping offset
// [RL13] tracking: changing preset 1 keeps preset 2, new offset
// [RL14] one resolution setting serves all timed outputs
// [RL15] fine resolution steps 0.01 s, up to 99.99 s
// [RL16] coarse resolution steps 0.1 s, up to 999.9 s
// [RL17] timed output 1 holds for its programmed duration
// [RL18] timed output 2 holds for its own duration
// [RL19] each output has its own inversion select
// [RL20] inverted outputs go off at activation, on at reset or end (rst holds out_q low; auto reset does not end a running timed output)
// [RL21] duration counts down once per resolution tick to zero
// [RL22] presets compare against the timer in its own units
module dpt_core (
    input  wire logic                          core_clk,    // system clock
    input  wire logic                          rst,         // sync reset
    input  wire dpt_pkg::dpt_cfg_t             cfg,         // menu settings
    input  wire logic                          pwr_up,      // power applied
    input  wire logic [dpt_pkg::DPT_VAL_W-1:0] saved_val,   // stored timer
    input  wire logic                          count_tick,  // timer step
    input  wire logic                          run_en,      // timing allowed
    input  wire logic                          man_reset,   // manual reset
    input  wire logic                          p1_wr,       // write preset 1
    input  wire logic                          p2_wr,       // write preset 2
    input  wire logic [dpt_pkg::DPT_VAL_W-1:0] p_wdata,     // preset data
    input  wire logic [7:0]                    acc_lvl,     // p1,p2,t1,t2
    input  wire logic                          prog_dis,    // disable lvl 1
    output logic [dpt_pkg::DPT_VAL_W-1:0]      timer_val,   // timer value
    output logic [dpt_pkg::DPT_VAL_W-1:0]      preset1,     // preset 1
    output logic [dpt_pkg::DPT_VAL_W-1:0]      preset2,     // preset 2
    output logic [1:0]                         out_q,       // outputs 1,2
    output logic                               halted,      // stopped at p2
    output logic [11:0]                        vis_q        // 3 bits/value
);
    import dpt_pkg::*;

    typedef struct packed {
        dpt_st_t              st;
        logic [DPT_VAL_W-1:0] tmr;
        logic [DPT_VAL_W-1:0] p1;
        logic [DPT_VAL_W-1:0] p2;
        logic [DPT_VAL_W-1:0] ofs;
        logic [1:0]           lat;
        logic [1:0]           out;
        logic [DPT_TICK_W-1:0] div;
        logic                 tick;
        logic                 o2_was;
        logic                 hlt;
        logic [11:0]          vis;
    } dpt_core_t;

    dpt_core_t s_q;
    dpt_core_t s_d;
    dpt_mode_t md;
    logic      [1:0] pls_act;
    logic      [1:0] pls_start;
    logic      clr_all;
    dpt_vis_t  vis_w [4];

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // modes 19..42 come in groups of five per reset type, then four
    function automatic dpt_mode_t dpt_decode(input logic [5:0] m);
        dpt_mode_t  r;
        logic [5:0] k;
        logic [2:0] o;
        r = '0;
        k = m - DPT_MODE_LO;
        o = 3'h0;
        if (m >= DPT_MODE_LO && m <= DPT_MODE_HI) begin
            r.valid = 1'b1;                                     // [RL1]
            if (k < 6'h14) begin
                r.auto_rst = (k >= 6'h0A);
                r.to_p2    = (k >= 6'h05 && k < 6'h0A) || (k >= 6'h0F);
                o          = 3'((k % 6'h05));
            end else begin
                r.auto_rst  = 1'b1;
                r.at_o2_end = 1'b1;
                r.to_p2     = (k >= 6'h16);
                o           = (k[0]) ? 3'h4 : 3'h2;
            end
            // output pattern 0..4: latched, t/l, t/t, off/l, off/t
            r.o1_timed  = (o == 3'h1) || (o == 3'h2);
            r.o1_off_p2 = (o == 3'h3) || (o == 3'h4);
            r.o2_timed  = (o == 3'h2) || (o == 3'h4);
        end
        return r;
    endfunction

    assign md = dpt_decode(cfg.op_mode);

    // ----------------------------------------------------------------
    // timed output counters, one resolution tick for both
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pls
            dpt_pulse u_pls (
                .core_clk (core_clk),
                .rst      (rst),
                .tick     (s_q.tick),                           // [RL14]
                .start    (pls_start[gi]),
                .clear    (clr_all),
                .dur      (gi == 0 ? cfg.dur1 : cfg.dur2),   // [RL17] [RL18]
                .active   (pls_act[gi])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : g_acc
            dpt_access u_acc (
                .level    (acc_lvl[2*gi +: 2]),                 // [RL4] [RL9]
                .prog_dis (prog_dis),
                .vis      (vis_w[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // timer, presets and outputs
    // ----------------------------------------------------------------
    logic hit1;
    logic hit2;
    logic o2_end;
    logic arst;
    logic [DPT_VAL_W-1:0] rst_val;

    always_comb begin
        s_d = s_q;
        // resolution tick from the core clock
        s_d.tick = 1'b0;
        if (s_q.div == '0) begin
            s_d.tick = 1'b1;
            s_d.div  = cfg.res_coarse ?                         // [RL15] [RL16]
                       DPT_TICK_W'(DPT_COARSE_CYC - 1) :
                       DPT_TICK_W'(DPT_FINE_CYC - 1);
        end else begin
            s_d.div = s_q.div - 1'b1;
        end
        // presets and tracking offset
        if (p2_wr) begin
            s_d.p2 = p_wdata;
            if (cfg.track_en) begin
                s_d.p1 = p_wdata - s_q.ofs;                     // [RL12]
            end
        end else if (p1_wr) begin
            s_d.p1  = p_wdata;
            s_d.ofs = s_q.p2 - p_wdata;                         // [RL13]
        end
        if (!cfg.track_en) begin
            s_d.ofs = s_d.p2 - s_d.p1;
        end
        // compare at each timer step in timer units
        // a step that is held off by run_en must not fire an output
        hit1 = run_en && count_tick && (s_q.tmr + 1'b1 == s_q.p1); // [RL22]
        hit2 = run_en && count_tick && (s_q.tmr + 1'b1 == s_q.p2); // [RL22]
        o2_end  = s_q.o2_was && !pls_act[1];
        rst_val = md.to_p2 ? s_q.p2 : '0;
        arst = md.auto_rst &&
               (md.at_o2_end ? o2_end : (s_q.st == DPT_HALT));
        s_d.o2_was = pls_act[1];
        case (s_q.st)
            DPT_IDLE: s_d.st = DPT_RUN;
            DPT_RUN: begin
                if (run_en && count_tick) begin
                    s_d.tmr = s_q.tmr + 1'b1;
                end
                if (hit1) begin
                    s_d.lat[0] = 1'b1;                          // [RL10]
                end
                if (hit2) begin
                    s_d.lat[1] = 1'b1;                          // [RL11]
                    if (md.o1_off_p2) begin
                        s_d.lat[0] = 1'b0;
                    end
                    if (md.valid) begin
                        s_d.st = DPT_HALT;                      // [RL1]
                    end
                end
            end
            DPT_HALT: begin
                if (arst && !md.at_o2_end) begin
                    s_d.st  = DPT_RUN;
                    s_d.tmr = rst_val;                          // [RL1]
                    s_d.lat = '0;
                end
            end
            default: s_d.st = DPT_IDLE;
        endcase
        if (man_reset || (md.at_o2_end && o2_end)) begin
            s_d.st  = DPT_RUN;
            s_d.tmr = rst_val;
            s_d.lat = '0;
        end
        if (pwr_up) begin
            s_d.tmr = cfg.pwr_rst_en ? '0 : saved_val;          // [RL2] [RL3]
            s_d.st  = DPT_RUN;
            s_d.lat = '0;
        end
        // timed outputs follow their counters, latched ones the latch
        s_d.out[0] = (md.o1_timed ? pls_act[0] : s_d.lat[0]) ^ cfg.invert[0];
        s_d.out[1] = (md.o2_timed ? pls_act[1] : s_d.lat[1]) ^ cfg.invert[1];
        for (int i = 0; i < 4; i++) begin
            s_d.vis[3*i +: 3] = vis_w[i];
        end
        // stop flag kept as its own flop so the port has no decode
        s_d.hlt = (s_d.st == DPT_HALT);
    end

    assign pls_start[0] = hit1 && (s_q.st == DPT_RUN);          // [RL17]
    assign pls_start[1] = hit2 && (s_q.st == DPT_RUN);          // [RL18]
    assign clr_all      = man_reset || pwr_up;                  // [RL20]

    // inversion is applied above as an xor per output          [RL19] [RL20]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.out <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign timer_val = s_q.tmr;
    assign preset1   = s_q.p1;
    assign preset2   = s_q.p2;
    assign out_q     = s_q.out;
    assign halted    = s_q.hlt;
    assign vis_q     = s_q.vis;
endmodule

/* inc/dpt_pkg.sv */
// dpt_pkg: shared constants and carrier types of the dual preset timer core.
// assumes a 200 MHz core clock and a host menu that drives the settings.
package dpt_pkg;

    // ------------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------------
    localparam int          DPT_VAL_W     = 20;
    localparam int          DPT_DUR_W     = 14;
    localparam int          DPT_MODE_W    = 6;
    localparam int          DPT_CLK_MHZ   = 200;
    localparam int          DPT_FINE_US   = 10000;   // 0.01 s step
    localparam int          DPT_COARSE_US = 100000;  // 0.1 s step
    localparam int          DPT_FINE_CYC  = DPT_FINE_US * DPT_CLK_MHZ;
    localparam int          DPT_COARSE_CYC = DPT_COARSE_US * DPT_CLK_MHZ;
    localparam int          DPT_TICK_W    = 25;
    localparam logic [13:0] DPT_DUR_MAX   = 14'h270F; // 9999 steps
    localparam logic [5:0]  DPT_MODE_LO   = 6'h13;    // mode 19
    localparam logic [5:0]  DPT_MODE_HI   = 6'h2A;    // mode 42

    // ------------------------------------------------------------------
    // access levels (preset and output-time values)
    // ------------------------------------------------------------------
    localparam logic [1:0]  DPT_ACC_LOCK  = 2'h0;
    localparam logic [1:0]  DPT_ACC_PROT  = 2'h1;
    localparam logic [1:0]  DPT_ACC_VIEW  = 2'h2;
    localparam logic [1:0]  DPT_ACC_FULL  = 2'h3;

    // visibility of one value
    typedef struct packed {
        logic show_main;   // shown on main display
        logic edit_main;   // editable from main display
        logic in_prot;     // listed in protected value menu
    } dpt_vis_t;

    // decoded operating mode
    typedef struct packed {
        logic valid;       // mode in 19..42
        logic auto_rst;    // automatic reset
        logic to_p2;       // reset value is preset 2
        logic at_o2_end;   // auto reset when timed output 2 ends
        logic o1_timed;
        logic o1_off_p2;   // output 1 off at preset 2
        logic o2_timed;
    } dpt_mode_t;

    // settings from the menu
    typedef struct packed {
        logic [DPT_MODE_W-1:0] op_mode;
        logic                  pwr_rst_en;   // clear timer at power-up
        logic                  track_en;     // preset 1 tracks preset 2
        logic                  res_coarse;   // 1: 0.1 s, 0: 0.01 s
        logic [1:0]            invert;       // per output inversion
        logic [DPT_DUR_W-1:0]  dur1;
        logic [DPT_DUR_W-1:0]  dur2;
    } dpt_cfg_t;

    typedef enum logic [1:0] {DPT_IDLE, DPT_RUN, DPT_HALT} dpt_st_t;

endpackage

/* design/dpt_pulse.sv */
// dpt_pulse: one timed output duration counter.
// assumes a shared resolution tick pulse from the parent.
`timescale 1ns/10ps
module dpt_pulse (
    input  wire logic                          core_clk, // system clock
    input  wire logic                          rst,      // sync reset
    input  wire logic                          tick,     // resolution tick
    input  wire logic                          start,    // begin duration
    input  wire logic                          clear,    // end at once
    input  wire logic [dpt_pkg::DPT_DUR_W-1:0] dur,      // steps to hold
    output logic                               active    // duration running
);
    import dpt_pkg::*;

    typedef struct packed {
        logic [DPT_DUR_W-1:0] cnt;
        logic                 act;
    } dpt_pls_t;

    dpt_pls_t s_q;
    dpt_pls_t s_d;

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    // a zero duration would never run, so it is held for one step
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d.act = 1'b0;
        end else if (start) begin
            s_d.act = 1'b1;
            s_d.cnt = (dur == '0) ? 14'h0001 :
                      ((dur > DPT_DUR_MAX) ? DPT_DUR_MAX : dur);
        end else if (s_q.act && tick) begin
            s_d.cnt = s_q.cnt - 14'h0001;           // [RL21]
            if (s_q.cnt == 14'h0001) begin
                s_d.act = 1'b0;                      // [RL21]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign active = s_q.act;
endmodule

/* design/dpt_access.sv */
// dpt_access: decodes one access level into visibility flags.
// assumes the level is a menu setting, stable between edits.
`timescale 1ns/10ps
module dpt_access (
    input  wire logic [1:0]       level,    // access level code
    input  wire logic             prog_dis, // program disable level 1
    output dpt_pkg::dpt_vis_t     vis       // visibility flags
);
    import dpt_pkg::*;

    // ----------------------------------------------------------------
    // level decode
    // ----------------------------------------------------------------
    always_comb begin
        vis = '0;
        case (level)
            DPT_ACC_LOCK: vis = '0;                        // [RL5]
            DPT_ACC_PROT: vis.in_prot = 1'b1;              // [RL6]
            DPT_ACC_VIEW: begin
                vis.show_main = 1'b1;                      // [RL7]
                vis.edit_main = ~prog_dis;
                vis.in_prot   = 1'b1;
            end
            DPT_ACC_FULL: begin
                vis.show_main = 1'b1;                      // [RL8]
                vis.edit_main = 1'b1;
            end
            default: vis = '0;
        endcase
    end
endmodule

/* dv/dpt_core_props.sv */
// dpt_core_props: concurrent checks on the timer core ports.
// assumes a bind onto dpt_core; one clock, sync reset high.
`timescale 1ns/10ps
module dpt_core_props (
    input wire logic              core_clk,   // clock
    input wire logic              rst,        // sync reset
    input wire dpt_pkg::dpt_cfg_t cfg,        // settings
    input wire logic              pwr_up,     // power applied
    input wire logic [19:0]       saved_val,  // stored timer
    input wire logic              count_tick, // timer step
    input wire logic              run_en,     // timing allowed
    input wire logic              man_reset,  // manual reset
    input wire logic              p1_wr,      // preset 1 write
    input wire logic              p2_wr,      // preset 2 write
    input wire logic [19:0]       p_wdata,    // preset data
    input wire logic [7:0]        acc_lvl,    // access levels
    input wire logic              prog_dis,   // disable level 1
    input wire logic [19:0]       timer_val,  // timer value
    input wire logic [19:0]       preset1,    // preset 1
    input wire logic [19:0]       preset2,    // preset 2
    input wire logic [1:0]        out_q,      // outputs
    input wire logic              halted,     // stopped at p2
    input wire logic [11:0]       vis_q       // visibility
);
    import dpt_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // expected flags {show_main, edit_main, in_prot} at level 1
    function automatic logic [2:0] vm(input logic [1:0] l);
        return (l == DPT_ACC_FULL) ? 3'h6 : (l == DPT_ACC_VIEW) ? 3'h5 :
               (l == DPT_ACC_PROT) ? 3'h1 : 3'h0;
    endfunction
    property p_pwr_keep;
        pwr_up && !cfg.pwr_rst_en |=> timer_val == $past(saved_val);
    endproperty
    a_pwr_keep: assert property (p_pwr_keep)
        else $error("stored timer not restored");
    property p_pwr_clr;
        pwr_up && cfg.pwr_rst_en |=> timer_val == 20'h00000;
    endproperty
    a_pwr_clr: assert property (p_pwr_clr)
        else $error("timer not cleared at power-up");
    // manual modes must sit still once stopped, ticks or not
    property p_halt_hold;
        halted && cfg.op_mode inside {[6'h13:6'h1C]} && !man_reset &&
        !pwr_up |=> halted && $stable(timer_val);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("timer moved while stopped");
    property p_p1_write;
        p1_wr && !p2_wr |=> preset1 == $past(p_wdata) && $stable(preset2);
    endproperty
    a_p1_write: assert property (p_p1_write)
        else $error("preset 1 write wrong");
    property p_track;
        cfg.track_en && p2_wr && !p1_wr |=> preset2 == $past(p_wdata) &&
        (preset2 - preset1) == $past(preset2 - preset1);
    endproperty
    a_track: assert property (p_track)
        else $error("tracking offset lost");
    property p_o1_hit;
        $past(count_tick) && $changed(timer_val) && timer_val == preset1 &&
        preset1 != preset2 && !cfg.invert[0] &&
        cfg.op_mode inside {[6'h13:6'h17]} |-> ##[0:1] out_q[0];
    endproperty
    a_o1_hit: assert property (p_o1_hit)
        else $error("output 1 missed preset 1");
    property p_o2_hit;
        $past(count_tick) && $changed(timer_val) && timer_val == preset2 &&
        !cfg.invert[1] && cfg.op_mode inside {[6'h13:6'h17]}
        |-> halted ##[0:1] out_q[1];
    endproperty
    a_o2_hit: assert property (p_o2_hit)
        else $error("output 2 or stop missed at preset 2");
    property p_vis;
        prog_dis && $past(prog_dis) && !$past(rst) |-> vis_q ==
        {vm($past(acc_lvl[7:6])), vm($past(acc_lvl[5:4])),
         vm($past(acc_lvl[3:2])), vm($past(acc_lvl[1:0]))};
    endproperty
    a_vis: assert property (p_vis)
        else $error("access visibility wrong");
    property p_inv;
        cfg.invert == 2'h3 && man_reset && cfg.op_mode inside {[6'h13:6'h1C]}
        |-> ##[1:2] out_q == 2'h3;
    endproperty
    a_inv: assert property (p_inv)
        else $error("inverted outputs not on after reset");
    c_halt: cover property (halted);
    c_o1: cover property ($rose(out_q[0]));
    c_track: cover property (cfg.track_en && p2_wr);
endmodule
bind dpt_core dpt_core_props u_props (.core_clk, .rst, .cfg, .pwr_up,
    .saved_val, .count_tick, .run_en, .man_reset, .p1_wr, .p2_wr, .p_wdata,
    .acc_lvl, .prog_dis, .timer_val, .preset1, .preset2, .out_q, .halted,
    .vis_q);

/* dv/dpt_load.sv */
// dpt_load: relay loads on the two timer outputs.
// assumes out_q high means coil driven.
`timescale 1ns/10ps
module dpt_load (
    input  wire logic       core_clk, // system clock
    input  wire logic       rst,      // sync reset
    input  wire logic [1:0] out_q,    // coil drive
    output logic      [1:0] load_on   // contacts closed
);
    // contacts follow the coil a cycle late, like a relay pull-in
    always_ff @(posedge core_clk) begin
        load_on <= rst ? 2'h0 : out_q;
    end
endmodule

/* dv/dpt_core_tb.sv */
// dpt_core_tb: directed bench for the dual preset timer core.
// assumes the timed counts are too long to run out; starts only.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module dpt_core_tb;
    import dpt_pkg::*;
    logic core_clk, rst, pwr_up, count_tick, run_en, man_reset;
    logic p1_wr, p2_wr, prog_dis, halted;
    logic [19:0] saved_val, p_wdata, timer_val, preset1, preset2;
    logic [7:0]  acc_lvl;
    logic [1:0]  out_q, load_on;
    logic [11:0] vis_q;
    dpt_cfg_t    cfg;
    int          checked = 0;
    int          fails = 0;
    dpt_core DUT (.core_clk, .rst, .cfg, .pwr_up, .saved_val, .count_tick,
        .run_en, .man_reset, .p1_wr, .p2_wr, .p_wdata, .acc_lvl,
        .prog_dis, .timer_val, .preset1, .preset2, .out_q, .halted, .vis_q);
    dpt_load u_load (.core_clk, .rst, .out_q, .load_on);
    // ------------------------------------------------------------
    // access tasks, all driven on the falling edge
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic tick(input int n);
        count_tick = 1'b1;
        cyc(n);
        count_tick = 1'b0;
        cyc(1);
    endtask
    // mode changes ride on a reset so a stopped timer never sees a switch
    task automatic mreset(input logic [5:0] m);
        cfg.op_mode = m;
        man_reset = 1'b1;
        cyc(1);
        man_reset = 1'b0;
        cyc(2);
    endtask
    task automatic wr(input logic sel, input logic [19:0] v);
        p1_wr = !sel;
        p2_wr = sel;
        p_wdata = v;
        cyc(1);
        p1_wr = 1'b0;
        p2_wr = 1'b0;
        cyc(1);
    endtask
    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // whole run is about 130 cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        cfg = '0;
        cfg.dur1 = 14'h0064;
        cfg.dur2 = 14'h0064;
        {pwr_up, count_tick, man_reset, p1_wr, p2_wr} = 5'h00;
        run_en = 1'b1;
        prog_dis = 1'b1;
        saved_val = 20'h00123;
        p_wdata = 20'h00000;
        acc_lvl = {DPT_ACC_FULL, DPT_ACC_VIEW, DPT_ACC_PROT, DPT_ACC_LOCK};
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        cyc(2);
        `CHK(vis_q, 12'hD48)
        acc_lvl = {DPT_ACC_LOCK, DPT_ACC_FULL, DPT_ACC_VIEW, DPT_ACC_PROT};
        cyc(2);
        `CHK(vis_q, 12'h1A9)
        pwr_up = 1'b1;
        cyc(1);
        pwr_up = 1'b0;
        cyc(1);
        `CHK(timer_val, 20'h00123)
        cfg.pwr_rst_en = 1'b1;
        pwr_up = 1'b1;
        cyc(1);
        pwr_up = 1'b0;
        cyc(1);
        `CHK(timer_val, 20'h00000)
        wr(1'b0, 20'h00005);
        wr(1'b1, 20'h00008);
        `CHK({preset1, preset2}, 40'h0000500008)
        // each inversion pattern over a full latched run to the stop
        for (int i = 0; i < 4; i++) begin
            cfg.invert = 2'(i);
            mreset(6'h13);
            `CHK(out_q, 2'(i))
            tick(5);
            `CHK(out_q, 2'(i) ^ 2'h1)
            tick(3);
            `CHK({halted, out_q}, {1'b1, 2'(i) ^ 2'h3})
            tick(2);
            `CHK(timer_val, 20'h00008)
            `CHK(load_on, 2'(i) ^ 2'h3)
        end
        cfg.invert = 2'h0;
        mreset(6'h18);
        `CHK(timer_val, 20'h00008)
        mreset(6'h1D);
        tick(8);
        cyc(2);
        `CHK(timer_val, 20'h00000)
        mreset(6'h01);
        tick(9);
        `CHK({halted, timer_val}, 21'h000009)
        // steps held off by run_en do not move the timer
        run_en = 1'b0;
        tick(3);
        `CHK(timer_val, 20'h00009)
        run_en = 1'b1;
        mreset(6'h14);
        tick(5);
        `CHK(out_q[0], 1'b1)
        cfg.track_en = 1'b1;
        wr(1'b1, 20'h00020);
        `CHK(preset1, 20'h0001D)
        wr(1'b0, 20'h00010);
        `CHK(preset2, 20'h00020)
        wr(1'b1, 20'h00030);
        `CHK(preset1, 20'h00020)
        end_of_test();
    end
endmodule
